// ===== verification/ccd_chroma_dma_chk.sv
`timescale 1ns/1ps
module ccd_chroma_dma_chk
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frame_start,
    input wire logic c_valid,
    input wire logic c_ready,
    input wire logic mem_valid,
    input wire ccd_pkg::ccd_wreq_s mem_req,
    input wire logic mem_ready,
    input wire logic [1:0] frame_slot,
    input wire logic decimate_en,
    input wire logic out_422,
    input wire logic frame_done
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic seen_q;
    wire fmt_wr = psel && penable && pready && pwrite && (paddr == ccd_pkg::FMT_ADDR);
    // first frame must stay on slot 0, so remember whether one began
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            seen_q <= 1'b0;
        else if (frame_start)
            seen_q <= 1'b1;
    end
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_err_unmapped: assert property (psel && penable && pready && paddr == 32'h4f00_0050 |-> pslverr)
        else $error("unmapped access not flagged");
    a_decim_follow: assert property (fmt_wr |-> ##2 decimate_en == !$past(pwdata[31], 2))
        else $error("decimation does not follow input select");
    a_out_follow: assert property (fmt_wr |-> ##2 out_422 == $past(pwdata[30], 2))
        else $error("output format does not follow select");
    a_slot_first: assert property (frame_start && !seen_q |=> frame_slot == 2'h0)
        else $error("first frame not on slot 0");
    a_slot_step: assert property (frame_start && seen_q |=> frame_slot == $past(frame_slot) + 2'h1)
        else $error("slot did not advance by one");
    a_word_gap: assert property (c_valid && c_ready |=> !c_ready && mem_valid)
        else $error("accepted word not forwarded");
    a_req_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
        else $error("memory request dropped or changed");
    a_done_pulse: assert property (frame_done |=> !frame_done)
        else $error("frame done longer than one cycle");
    cover property (frame_done);
    cover property (mem_valid && !mem_ready);
    cover property (pslverr);
endmodule

// ===== verification/ccd_mem_model.sv
`timescale 1ns/1ps
module ccd_mem_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_valid,
    input wire ccd_pkg::ccd_wreq_s mem_req,
    input wire logic slow,
    output logic mem_ready
);
    logic [1:0] cnt_q;
    logic [31:0] addr_log[$];
    logic [31:0] data_log[$];
    // slow mode stalls half the time so held requests get exercised
    assign mem_ready = mem_valid & (~slow | cnt_q[1]);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 2'h0;
        else
            cnt_q <= cnt_q + 2'h1;
    end
    always @(posedge pclk)
    begin
        if (mem_valid && mem_ready)
        begin
            addr_log.push_back(mem_req.addr);
            data_log.push_back(mem_req.data);
        end
    end
endmodule

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic pclk, presetn, psel, penable, pwrite, frame_start, c_valid, mem_ready, slow;
    logic pready, pslverr, c_ready, mem_valid, decimate_en, out_422, frame_done, err;
    logic [31:0] paddr, pwdata, prdata, rd, d, a, ex;
    logic [1:0] frame_slot, fs;
    ccd_pkg::ccd_chroma_s c_word;
    ccd_pkg::ccd_wreq_s mem_req;
    int n_errors = 0, tests_run = 0, cyc = 0, i, k, n, row, col;
    ccd_chroma_dma dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_start(frame_start), .c_valid(c_valid), .c_word(c_word),
        .c_ready(c_ready), .mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready),
        .frame_slot(frame_slot), .decimate_en(decimate_en), .out_422(out_422),
        .frame_done(frame_done)
    );
    ccd_mem_model mem (
        .pclk(pclk), .presetn(presetn), .mem_valid(mem_valid), .mem_req(mem_req),
        .slow(slow), .mem_ready(mem_ready)
    );
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            test_done();
        end
    end
    task test_done;
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task send(input logic cr, input logic [31:0] wd);
        @(posedge pclk);
        c_valid <= 1'b1;
        c_word <= {cr, wd};
        do @(posedge pclk); while (c_ready !== 1'b1);
        c_valid <= 1'b0;
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, frame_start, c_valid, slow} = 7'h00;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        c_word = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 9; i++)
        begin
            a = ccd_pkg::CB1_ADDR + 32'(i * 4);
            apb(1'b0, a, 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            apb(1'b1, a, 32'hffff_ffff ^ 32'(i));
            apb(1'b0, a, 32'h0000_0000);
            chk(rd, (32'hffff_ffff ^ 32'(i)) & (i == 8 ? ccd_pkg::FMT_WMASK : 32'hffff_ffff));
        end
        apb(1'b1, 32'h4f00_0050, 32'hffff_ffff);
        chk(err, 1'b1);
        apb(1'b0, 32'h4f00_0050, 32'h0000_0000);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, ccd_pkg::CB1_ADDR + 32'(i * 4), 32'h0010_0000 + 32'(i * 1024));
            apb(1'b1, ccd_pkg::CR1_ADDR + 32'(i * 4), 32'h0020_0000 + 32'(i * 1024));
        end
        for (i = 0; i < 4; i++)
        begin
            fs = 2'(i);
            apb(1'b1, ccd_pkg::FMT_ADDR, {fs, 1'b0, 13'd16, fs, 1'b0, fs[0] ? 13'd2 : 13'd4});
            slow <= fs[0];
            @(posedge pclk);
            frame_start <= 1'b1;
            @(posedge pclk);
            frame_start <= 1'b0;
            @(negedge pclk);
            chk(frame_slot, fs);
            chk(decimate_en, !fs[1]);
            chk(out_422, fs[0]);
            for (k = 0; k < 8; k++)
                send(k[0], {8'(k), 8'h5c, 8'h3a, 6'h0, fs});
            do @(negedge pclk); while (frame_done !== 1'b1);
            // last word is still in flight when the frame ends
            while (mem_valid !== 1'b0) @(negedge pclk);
            chk(mem.addr_log.size(), 8);
            for (k = 0; k < 8; k++)
            begin
                n = k / 2;
                row = fs[0] ? 1 - n / 2 : n / 2;
                col = fs[1] ? 1 - n % 2 : n % 2;
                a = (k[0] ? 32'h0020_0000 : 32'h0010_0000) + 32'(i * 1024 + (row * 2 + col) * 4);
                d = {8'(k), 8'h5c, 8'h3a, 6'h0, fs};
                ex = fs[1] ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
                chk(mem.addr_log[k], a);
                chk(mem.data_log[k], ex);
            end
            mem.addr_log.delete();
            mem.data_log.delete();
        end
        apb(1'b0, ccd_pkg::STAT_ADDR, 32'h0000_0000);
        chk(rd, 32'h0000_0403);
        test_done();
    end
endmodule
bind ccd_chroma_dma ccd_chroma_dma_chk chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .c_valid(c_valid), .c_ready(c_ready),
    .mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready),
    .frame_slot(frame_slot), .decimate_en(decimate_en), .out_422(out_422),
    .frame_done(frame_done)
);

// ===== verilog/ccd_chroma_dma.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module ccd_chroma_dma
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_start,
    input wire logic c_valid,
    input wire ccd_pkg::ccd_chroma_s c_word,
    output logic c_ready,
    output logic mem_valid,
    output ccd_pkg::ccd_wreq_s mem_req,
    input wire logic mem_ready,
    output logic [1:0] frame_slot,
    output logic decimate_en,
    output logic out_422,
    output logic frame_done
);
    logic [31:0] cb_base_q [ccd_pkg::NUM_SLOTS];
    logic [31:0] cr_base_q [ccd_pkg::NUM_SLOTS];
    logic [31:0] fmt_q;
    logic [1:0] slot_q;
    logic started_q;
    logic [7:0] frame_cnt_q;
    ccd_pkg::ccd_state_e state_q;
    ccd_pkg::ccd_fmt_s run_q;
    logic [31:0] run_base_q [2];
    logic [ccd_pkg::DIM_W-1:0] line_q [2];
    logic [ccd_pkg::DIM_W-1:0] word_q [2];
    logic [1:0] pdone_q;
    logic [ccd_pkg::DIM_W-1:0] lines_run;
    logic [ccd_pkg::DIM_W-1:0] words_run;
    logic [ccd_pkg::DIM_W-1:0] lines_new;
    logic [ccd_pkg::DIM_W-1:0] words_new;
    ccd_pkg::ccd_fmt_s fmt_new;
    logic [1:0] slot_nxt;
    logic accept;
    logic plane;
    logic mem_valid_d;
    logic run_d;
    logic last_word;
    logic last_line;
    logic [31:0] rd_val;
    logic rd_err;

    function automatic ccd_pkg::ccd_fmt_s unpack_fmt(input logic [31:0] r);
        ccd_pkg::ccd_fmt_s f;
        f.in_422 = r[ccd_pkg::IN_SEL_BIT];
        f.out_422 = r[ccd_pkg::OUT_SEL_BIT];
        f.width = r[ccd_pkg::WIDTH_LSB +: ccd_pkg::DIM_W];
        f.orient = r[ccd_pkg::ORIENT_LSB +: 2];
        f.height = r[ccd_pkg::HEIGHT_LSB +: ccd_pkg::DIM_W];
        return f;
    endfunction

    // stored chroma lines: full height for 4:2:2, half for 4:2:0
    function automatic logic [ccd_pkg::DIM_W-1:0] chroma_lines(input ccd_pkg::ccd_fmt_s f);
        return f.out_422 ? f.height : (f.height >> 1);
    endfunction

    function automatic logic [ccd_pkg::DIM_W-1:0] chroma_words(input ccd_pkg::ccd_fmt_s f);
        return f.width >> ccd_pkg::WORD_SHIFT;
    endfunction

    // word address after orientation; rows and columns flip independently
    function automatic logic [31:0] word_addr(
        input logic [31:0] base,
        input logic [ccd_pkg::DIM_W-1:0] line,
        input logic [ccd_pkg::DIM_W-1:0] word,
        input logic [ccd_pkg::DIM_W-1:0] lines,
        input logic [ccd_pkg::DIM_W-1:0] words,
        input logic [1:0] orient
    );
        logic [31:0] row, col;
        row = orient[ccd_pkg::ORI_ROW_BIT] ? 32'(lines - line - 13'h1) : 32'(line);
        col = orient[ccd_pkg::ORI_COL_BIT] ? 32'(words - word - 13'h1) : 32'(word);
        return base + ((row * 32'(words) + col) << ccd_pkg::BYTE_SHIFT);
    endfunction

    assign fmt_new = ccd_pkg::ccd_fmt_s'(unpack_fmt(fmt_q));
    assign lines_new = chroma_lines(fmt_new);
    assign words_new = chroma_words(fmt_new);
    assign lines_run = chroma_lines(run_q);
    assign words_run = chroma_words(run_q);
    assign slot_nxt = started_q ? slot_q + 2'h1 : slot_q;
    assign plane = c_word.is_cr;
    assign accept = c_valid && c_ready;
    assign last_word = word_q[plane] == words_run - 13'h1;
    assign last_line = line_q[plane] == lines_run - 13'h1;
    assign mem_valid_d = accept || (mem_valid && !mem_ready);

    always_comb
    begin
        run_d = state_q == ccd_pkg::CCD_RUN;
        if (frame_start)
        begin
            run_d = lines_new != '0 && words_new != '0;
        end
        else if (accept && last_word && last_line && pdone_q[!plane])
        begin
            run_d = 1'b0;
        end
    end

    always_comb
    begin
        rd_err = 1'b0;
        rd_val = '0;
        case (paddr)
            ccd_pkg::CB1_ADDR: rd_val = cb_base_q[0];
            ccd_pkg::CB2_ADDR: rd_val = cb_base_q[1];
            ccd_pkg::CB3_ADDR: rd_val = cb_base_q[2];
            ccd_pkg::CB4_ADDR: rd_val = cb_base_q[3];
            ccd_pkg::CR1_ADDR: rd_val = cr_base_q[0];
            ccd_pkg::CR2_ADDR: rd_val = cr_base_q[1];
            ccd_pkg::CR3_ADDR: rd_val = cr_base_q[2];
            ccd_pkg::CR4_ADDR: rd_val = cr_base_q[3];
            ccd_pkg::FMT_ADDR: rd_val = fmt_q;
            ccd_pkg::STAT_ADDR:
            begin
                rd_val[ccd_pkg::STAT_SLOT_LSB +: 2] = slot_q;
                rd_val[ccd_pkg::STAT_BUSY_BIT] = state_q == ccd_pkg::CCD_RUN;
                rd_val[ccd_pkg::STAT_CNT_LSB +: 8] = frame_cnt_q;
            end
            default: rd_err = 1'b1;
        endcase
    end

    // answer one cycle after setup: zero wait states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= psel && !penable;
            if (psel && !penable)
            begin
                pslverr <= rd_err;
                prdata <= pwrite ? '0 : rd_val;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cb_base_q <= '{default: ccd_pkg::BASE_RESET};
            cr_base_q <= '{default: ccd_pkg::BASE_RESET};
            fmt_q <= ccd_pkg::FMT_RESET;
        end
        else if (psel && penable && pready && pwrite)
        begin
            case (paddr)
                ccd_pkg::CB1_ADDR: cb_base_q[0] <= pwdata;
                ccd_pkg::CB2_ADDR: cb_base_q[1] <= pwdata;
                ccd_pkg::CB3_ADDR: cb_base_q[2] <= pwdata;
                ccd_pkg::CB4_ADDR: cb_base_q[3] <= pwdata;
                ccd_pkg::CR1_ADDR: cr_base_q[0] <= pwdata;
                ccd_pkg::CR2_ADDR: cr_base_q[1] <= pwdata;
                ccd_pkg::CR3_ADDR: cr_base_q[2] <= pwdata;
                ccd_pkg::CR4_ADDR: cr_base_q[3] <= pwdata;
                ccd_pkg::FMT_ADDR: fmt_q <= pwdata & ccd_pkg::FMT_WMASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            decimate_en <= 1'b1;
            out_422 <= 1'b0;
        end
        else
        begin
            decimate_en <= !fmt_q[ccd_pkg::IN_SEL_BIT];
            out_422 <= fmt_q[ccd_pkg::OUT_SEL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_q <= '0;
            started_q <= 1'b0;
            frame_slot <= '0;
        end
        else
        begin
            if (frame_start)
            begin
                slot_q <= slot_nxt;
                started_q <= 1'b1;
                frame_slot <= slot_nxt;
            end
        end
    end

    // config and bases latched at frame start for the DMA; decimate_en and out_422 follow fmt_q, so a mid-frame format write changes them
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_q <= '0;
            run_base_q <= '{default: ccd_pkg::BASE_RESET};
        end
        else if (frame_start)
        begin
            run_q <= fmt_new;
            run_base_q <= '{cb_base_q[slot_nxt], cr_base_q[slot_nxt]};
        end
    end

    // line and word counting per plane
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_q <= '{default: '0};
            word_q <= '{default: '0};
            pdone_q <= '0;
        end
        else if (frame_start)
        begin
            line_q <= '{default: '0};
            word_q <= '{default: '0};
            pdone_q <= '0;
        end
        else if (accept)
        begin
            if (last_word)
            begin
                word_q[plane] <= '0;
                if (last_line)
                begin
                    pdone_q[plane] <= 1'b1;
                end
                else
                begin
                    line_q[plane] <= line_q[plane] + 13'h1;
                end
            end
            else
            begin
                word_q[plane] <= word_q[plane] + 13'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ccd_pkg::CCD_IDLE;
            frame_done <= 1'b0;
            frame_cnt_q <= '0;
        end
        else
        begin
            frame_done <= 1'b0;
            case (state_q)
                ccd_pkg::CCD_IDLE:
                begin
                    if (run_d)
                    begin
                        state_q <= ccd_pkg::CCD_RUN;
                    end
                end
                ccd_pkg::CCD_RUN:
                begin
                    if (!run_d)
                    begin
                        state_q <= ccd_pkg::CCD_IDLE;
                        frame_done <= 1'b1;
                        frame_cnt_q <= frame_cnt_q + 8'h1;
                    end
                end
                default: state_q <= ccd_pkg::CCD_IDLE;
            endcase
        end
    end

    // one word in flight: halves throughput but keeps c_ready a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            c_ready <= 1'b0;
            mem_valid <= 1'b0;
            mem_req <= '0;
        end
        else
        begin
            mem_valid <= mem_valid_d;
            c_ready <= run_d && !mem_valid_d && !frame_start;
            if (accept)
            begin
                mem_req.addr <= word_addr(run_base_q[plane], line_q[plane], word_q[plane],
                    lines_run, words_run, run_q.orient);
                mem_req.data <= run_q.orient[ccd_pkg::ORI_COL_BIT] ?
                    {c_word.data[7:0], c_word.data[15:8], c_word.data[23:16],
                    c_word.data[31:24]} : c_word.data;
            end
        end
    end
endmodule

// ===== verilog/ccd_pkg.sv
package ccd_pkg;
    // register byte addresses
    localparam logic [31:0] CB1_ADDR = 32'h4f00_0028;
    localparam logic [31:0] CB2_ADDR = 32'h4f00_002c;
    localparam logic [31:0] CB3_ADDR = 32'h4f00_0030;
    localparam logic [31:0] CB4_ADDR = 32'h4f00_0034;
    localparam logic [31:0] CR1_ADDR = 32'h4f00_0038;
    localparam logic [31:0] CR2_ADDR = 32'h4f00_003c;
    localparam logic [31:0] CR3_ADDR = 32'h4f00_0040;
    localparam logic [31:0] CR4_ADDR = 32'h4f00_0044;
    localparam logic [31:0] FMT_ADDR = 32'h4f00_0048;
    localparam logic [31:0] STAT_ADDR = 32'h4f00_00f0;

    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam logic [31:0] FMT_RESET = 32'h0000_0000;
    // writable bits of the format register; 29 and 13 are reserved
    localparam logic [31:0] FMT_WMASK = 32'hdfff_dfff;

    // format register fields
    localparam int IN_SEL_BIT = 31;
    localparam int OUT_SEL_BIT = 30;
    localparam int WIDTH_LSB = 16;
    localparam int ORIENT_LSB = 14;
    localparam int HEIGHT_LSB = 0;
    localparam int DIM_W = 13;

    // status register fields
    localparam int STAT_SLOT_LSB = 0;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_CNT_LSB = 8;

    // orientation codes; bit 0 flips rows, bit 1 flips columns
    localparam logic [1:0] ORI_NORMAL = 2'h0;
    localparam logic [1:0] ORI_X_MIRROR = 2'h1;
    localparam logic [1:0] ORI_Y_MIRROR = 2'h2;
    localparam logic [1:0] ORI_ROT180 = 2'h3;
    localparam int ORI_ROW_BIT = 0;
    localparam int ORI_COL_BIT = 1;

    // chroma samples are half the luma width, four per word
    localparam int WORD_SHIFT = 3;
    localparam int BYTE_SHIFT = 2;
    localparam int NUM_SLOTS = 4;

    typedef enum logic {CCD_IDLE, CCD_RUN} ccd_state_e;

    typedef struct packed {
        logic is_cr;
        logic [31:0] data;
    } ccd_chroma_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
    } ccd_wreq_s;

    typedef struct packed {
        logic in_422;
        logic out_422;
        logic [DIM_W-1:0] width;
        logic [1:0] orient;
        logic [DIM_W-1:0] height;
    } ccd_fmt_s;
endpackage
